// >>> scp_pkg.sv
package scp_pkg;

   // frame layout: address word, then data word, each msb first
   localparam int          WORD_W      = 8;
   localparam logic [2:0]  BIT_LAST    = 3'h7;
   localparam logic [3:0]  FRAME_LAST  = 4'hF;
   localparam logic [3:0]  ADDR_BITS   = 4'h8;
   localparam int          IDX_LSB     = 2;
   localparam int          IDX_W       = 6;
   localparam int          REG_NUM_DEF = 32;

   // register indices with fixed content, and which ones refuse writes
   localparam logic [5:0]  IDX_PART    = 6'h00;
   localparam logic [5:0]  IDX_RXSTAT  = 6'h18;
   localparam logic [5:0]  IDX_TESTMON = 6'h1D;
   localparam logic [63:0] RO_MASK     = 64'h0000_0000_2F00_0001;
   localparam logic [7:0]  PART_CODE   = 8'h5A;  // arbitrary value

   // timing: shift clock limit against the core clock
   localparam longint CORE_HZ       = 250_000_000;
   localparam longint SCLK_MAX_HZ   = 11_000_000;
   localparam int     SCLK_HALF_CYC = int'((CORE_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ));
   localparam int     SYNC_LAT      = 3;

   // transceiver clock division of the master clock
   localparam longint MCLK_NOM_HZ   = 44_000_000;
   localparam int     XCVR_DIV_A    = 2;
   localparam int     XCVR_DIV_B    = 4;

   typedef enum {DV_ADDR, DV_DATA, DV_DONE} scp_dev_ph_t;
   typedef enum {HS_IDLE, HS_LOW, HS_HIGH, HS_TAIL} scp_host_st_t;

endpackage

// >>> scp_if.sv
`timescale 1ns/1ns
interface scp_if;
   logic sclk;
   logic cs_n;
   logic rw;
   logic three_wire_data_in;
   logic sd_host_o;
   logic sd_host_oe;
   logic sd_dev_o;
   logic sd_dev_oe;
   logic ctrl_serial_io;

   // resolved level of the shared data line; weak pull-up when nobody drives
   // the host wins a short overlap at the address-to-read turnaround
   assign ctrl_serial_io = sd_host_oe ? sd_host_o : (sd_dev_oe ? sd_dev_o : 1'b1);

   modport host (
      output sclk,
      output cs_n,
      output rw,
      output three_wire_data_in,
      output sd_host_o,
      output sd_host_oe,
      input  ctrl_serial_io
   );

   modport dev (
      input  sclk,
      input  cs_n,
      input  rw,
      input  three_wire_data_in,
      input  ctrl_serial_io,
      output sd_dev_o,
      output sd_dev_oe
   );
endinterface

// >>> scp_host.sv
`timescale 1ns/1ns
module scp_host
   import scp_pkg::*;
#(
   parameter int HALF_CYC = SCLK_HALF_CYC
) (
   input  wire logic       core_clk,
   input  wire logic       rst,
   scp_if.host             bus,
   input  wire logic       start,
   input  wire logic       rd,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   output logic            busy,
   output logic            done,
   output logic [7:0]      rdata
);

   // the shift clock limit and the device synchroniser both bound the half period
   if (HALF_CYC < SCLK_HALF_CYC || HALF_CYC < SYNC_LAT + 1 || HALF_CYC > 65536) begin : g_half_chk
      $error("scp_host: HALF_CYC out of range");
   end

   typedef struct packed {
      scp_host_st_t st;
      logic [15:0]  div;
      logic [3:0]   bitn;
      logic [15:0]  frame;
      logic [7:0]   rsh;
      logic         rd;
      logic         sclk;
      logic         cs_n;
      logic         sd_o;
      logic         sd_oe;
      logic [1:0]   sd_sy;
      logic         done;
      logic [7:0]   rdata;
   } scp_host_s_t;

   scp_host_s_t st_reg;
   scp_host_s_t st_next;

   wire logic half_end = (st_reg.div == 16'(HALF_CYC - 1));

   // frame sequencer: one bit per shift clock period, host changes data while low
   always_comb begin
      st_next       = st_reg;
      st_next.sd_sy = {st_reg.sd_sy[0], bus.ctrl_serial_io};
      st_next.done  = 1'b0;
      st_next.div   = half_end ? 16'h0000 : st_reg.div + 16'h0001;
      case (st_reg.st)
         HS_IDLE: begin
            st_next.div = 16'h0000;
            if (start) begin
               st_next.st    = HS_LOW;
               st_next.rd    = rd;
               st_next.frame = {addr, wdata};
               st_next.bitn  = 4'h0;
               st_next.cs_n  = 1'b0;
               st_next.sd_o  = addr[7];
               st_next.sd_oe = 1'b1;
            end
         end
         HS_LOW: begin
            if (half_end) begin
               st_next.sclk = 1'b1;
               st_next.st   = HS_HIGH;
               if (st_reg.rd && st_reg.bitn >= ADDR_BITS) begin
                  st_next.rsh = {st_reg.rsh[6:0], st_reg.sd_sy[1]};
               end
            end
         end
         HS_HIGH: begin
            if (half_end) begin
               st_next.sclk = 1'b0;
               if (st_reg.bitn == FRAME_LAST) begin
                  st_next.st    = HS_TAIL;
                  st_next.sd_oe = 1'b0;
               end else begin
                  st_next.st    = HS_LOW;
                  st_next.bitn  = st_reg.bitn + 4'h1;
                  st_next.frame = {st_reg.frame[14:0], 1'b0};
                  st_next.sd_o  = st_reg.frame[14];
                  // release the line for the whole data word of a read
                  st_next.sd_oe = !(st_reg.rd && (st_reg.bitn + 4'h1) >= ADDR_BITS);
               end
            end
         end
         HS_TAIL: begin
            if (half_end) begin
               st_next.st    = HS_IDLE;
               st_next.cs_n  = 1'b1;
               st_next.done  = 1'b1;
               st_next.rdata = st_reg.rd ? st_reg.rsh : st_reg.rdata;
            end
         end
         default: st_next.st = HS_IDLE;
      endcase
   end

   // register the whole state; reset returns the port to idle and deselected
   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_reg       <= '0;
         st_reg.st    <= HS_IDLE;
         st_reg.cs_n  <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // direction is held for the whole frame, so it is set before the first rise
   assign bus.rw                 = st_reg.rd;
   assign bus.sclk               = st_reg.sclk;
   assign bus.cs_n               = st_reg.cs_n;
   assign bus.sd_host_o          = st_reg.sd_o;
   assign bus.sd_host_oe         = st_reg.sd_oe;
   assign bus.three_wire_data_in = 1'b0;
   assign busy                   = (st_reg.st != HS_IDLE);
   assign done                   = st_reg.done;
   assign rdata                  = st_reg.rdata;

endmodule

// >>> scp_dev.sv
`timescale 1ns/1ns
// Function
// - one shared line carries address and data
// - every word shifts most significant bit first
// - eight address bits, then eight data bits
// - device samples and shifts on shift-clock rise
// - shift clock is asynchronous to master clock
// - host keeps shift clock under limit
// - direction high reads, low writes
// - direction enables the read shift register
// - host sets direction before the rising edge
// - port works only while select is low
// - select leaves transmit and receive alone
// - inactive select ignores data, clock, direction
// - host drives unused three-wire input
// - master reset disables transmit and receive
// - master reset held low enters standby
// - master reset keeps configuration register contents
// - host programs registers after power-up
// - transceiver clocks divide master clock by 2/4
// - two address low bits are ignored
// - inactive select aborts any partial transfer
// - master clock keeps running while programming
module scp_dev
   import scp_pkg::*;
#(
   parameter int REG_NUM = REG_NUM_DEF
) (
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   scp_if.dev                        bus,
   input  wire logic                 master_rst_n,
   input  wire logic [31:0]          rx_status,
   input  wire logic [7:0]           test_monitor,
   output logic [REG_NUM*WORD_W-1:0] cfg_regs,
   output logic                      cfg_wr_pulse,
   output logic [IDX_W-1:0]          cfg_wr_idx,
   output logic                      txrx_enable,
   output logic                      standby,
   output logic                      xcvr_clk_div2,
   output logic                      xcvr_clk_div4
);

   // the index field is six bits wide, so more registers cannot be reached
   if (REG_NUM < 30 || REG_NUM > (1 << IDX_W)) begin : g_reg_num_chk
      $error("scp_dev: REG_NUM must lie between 30 and 64");
   end

   typedef struct packed {
      // synchroniser stages first, then frame state, then the register array
      logic [2:0]              sclk_sy;
      logic [1:0]              cs_sy;
      logic [1:0]              rw_sy;
      logic [1:0]              sd_sy;
      logic [1:0]              mrst_sy;
      scp_dev_ph_t             ph;
      logic [2:0]              cnt;
      logic [7:0]              in_sh;
      logic [7:0]              out_sh;
      logic [IDX_W-1:0]        idx;
      logic                    sd_o;
      logic                    rd_act;
      logic                    wr_pulse;
      logic [1:0]              div;
      logic                    txrx_en;
      logic                    stby;
      logic [REG_NUM-1:0][7:0] regs;
   } scp_dev_s_t;

   scp_dev_s_t st_reg;
   scp_dev_s_t st_next;

   logic             sclk_rise;
   logic             sel;
   logic             rw_rd;
   logic             sd_bit;
   logic [7:0]       addr_word;
   logic [IDX_W-1:0] addr_idx;
   logic [7:0]       rd_word;

   // second stage onward only; the first stage of each chain feeds nothing else
   assign sclk_rise = st_reg.sclk_sy[1] && !st_reg.sclk_sy[2];
   assign sel       = !st_reg.cs_sy[1];
   assign rw_rd     = st_reg.rw_sy[1];
   assign sd_bit    = st_reg.sd_sy[1];
   assign addr_word = {st_reg.in_sh[6:0], sd_bit};
   assign addr_idx  = addr_word[IDX_LSB +: IDX_W];

   // read source: status bytes and the part code come from outside the array
   // an entry never written reads back whatever the array happens to hold
   always_comb begin
      rd_word = 8'h00;
      if (addr_idx == IDX_PART) begin
         rd_word = PART_CODE;
      end else if (addr_idx >= IDX_RXSTAT && addr_idx < IDX_RXSTAT + 6'h04) begin
         rd_word = rx_status[8 * (3 - int'(addr_idx - IDX_RXSTAT)) +: 8];
      end else if (addr_idx == IDX_TESTMON) begin
         rd_word = test_monitor;
      end else if (int'(addr_idx) < REG_NUM) begin
         rd_word = st_reg.regs[addr_idx];
      end
   end

   // synchronisers, master reset handling and the serial frame decoder
   always_comb begin
      st_next          = st_reg;
      st_next.sclk_sy  = {st_reg.sclk_sy[1:0], bus.sclk};
      st_next.cs_sy    = {st_reg.cs_sy[0], bus.cs_n};
      st_next.rw_sy    = {st_reg.rw_sy[0], bus.rw};
      st_next.sd_sy    = {st_reg.sd_sy[0], bus.ctrl_serial_io};
      st_next.mrst_sy  = {st_reg.mrst_sy[0], master_rst_n};
      st_next.wr_pulse = 1'b0;

      // master reset only drives the transceiver enable and standby; select plays no part here
      st_next.txrx_en  = st_reg.mrst_sy[1];
      st_next.stby     = !st_reg.mrst_sy[1];
      st_next.div      = st_reg.div + 2'h1;

      if (!sel) begin
         // deselect drops any half-done frame and the line at once
         st_next.ph     = DV_ADDR;
         st_next.cnt    = 3'h0;
         st_next.rd_act = 1'b0;
      end else if (sclk_rise) begin
         case (st_reg.ph)
            DV_ADDR: begin
               st_next.in_sh = addr_word;
               st_next.cnt   = st_reg.cnt + 3'h1;
               if (st_reg.cnt == BIT_LAST) begin
                  st_next.ph     = DV_DATA;
                  st_next.cnt    = 3'h0;
                  st_next.idx    = addr_idx;
                  st_next.rd_act = rw_rd;
                  st_next.sd_o   = rd_word[7];
                  st_next.out_sh = {rd_word[6:0], 1'b0};
               end
            end
            DV_DATA: begin
               // a read shifts out and a write shifts in, eight rises either way
               st_next.cnt = st_reg.cnt + 3'h1;
               if (st_reg.rd_act) begin
                  // next bit goes out after the rise the host sampled on
                  st_next.sd_o   = st_reg.out_sh[7];
                  st_next.out_sh = {st_reg.out_sh[6:0], 1'b0};
               end else begin
                  st_next.in_sh = addr_word;
               end
               if (st_reg.cnt == BIT_LAST) begin
                  st_next.ph     = DV_DONE;
                  st_next.rd_act = 1'b0;
                  // read-only and out-of-range indexes drop the write without a sign
                  if (!st_reg.rd_act && !RO_MASK[st_reg.idx] && int'(st_reg.idx) < REG_NUM) begin
                     st_next.regs[st_reg.idx] = addr_word;
                     st_next.wr_pulse         = 1'b1;
                  end
               end
            end
            DV_DONE: begin
               // extra clocks within one select are ignored until deselect
               st_next.ph = DV_DONE;
            end
            default: st_next.ph = DV_ADDR;
         endcase
      end
   end

   // the register array is left alone by reset; only control state is cleared
   always_ff @(posedge core_clk) begin
      if (rst) begin
         // select presets high so no frame starts before the pins are seen
         st_reg.sclk_sy  <= 3'h0;
         st_reg.cs_sy    <= 2'h3;
         st_reg.rw_sy    <= 2'h0;
         st_reg.sd_sy    <= 2'h3;
         st_reg.mrst_sy  <= 2'h0;
         st_reg.ph       <= DV_ADDR;
         st_reg.cnt      <= 3'h0;
         st_reg.in_sh    <= 8'h00;
         st_reg.out_sh   <= 8'h00;
         st_reg.idx      <= '0;
         st_reg.sd_o     <= 1'b0;
         st_reg.rd_act   <= 1'b0;
         st_reg.wr_pulse <= 1'b0;
         st_reg.div      <= 2'h0;
         st_reg.txrx_en  <= 1'b0;
         st_reg.stby     <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // drive the data line only through the read word, and only while the
   // direction input still says read; a late direction change releases it
   assign bus.sd_dev_o  = st_reg.sd_o;
   assign bus.sd_dev_oe = st_reg.rd_act && rw_rd && sel;

   // cfg_regs comes straight from the array, so no reset disturbs it; reset clears the other outputs but sets standby
   assign cfg_regs      = st_reg.regs;
   assign cfg_wr_pulse  = st_reg.wr_pulse;
   assign cfg_wr_idx    = st_reg.idx;
   assign txrx_enable   = st_reg.txrx_en;
   assign standby       = st_reg.stby;

   // free-running dividers keep going through master reset
   assign xcvr_clk_div2 = st_reg.div[0];
   assign xcvr_clk_div4 = st_reg.div[1];

endmodule

// >>> scp_properties.sv
`timescale 1ns/1ns
module scp_properties (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic rw,
   input wire logic sd_host_oe,
   input wire logic sd_dev_oe,
   input wire logic sd_dev_o,
   input wire logic ctrl_serial_io
);
   typedef struct packed {
      logic       sclk_d;
      logic [4:0] rises;
   } scp_chk_st_t;
   scp_chk_st_t st_reg;
   scp_chk_st_t st_next;

   // shift-clock rises of the current frame; raised select clears the count
   always_comb begin
      st_next = st_reg;
      st_next.sclk_d = sclk;
      if (cs_n) begin
         st_next.rises = 5'h00;
      end else if (sclk && !st_reg.sclk_d) begin
         st_next.rises = st_reg.rises + 5'h01;
      end
   end
   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   AST_SCLK_SELECTED: assert property (sclk |-> !cs_n)
      else $error("shift clock high while port not selected");
   AST_FRAME_OPENS: assert property ($fell(cs_n) |-> !sclk && sd_host_oe)
      else $error("frame opened without host driving the line");
   AST_SCLK_HIGH: assert property ($rose(sclk) |=> sclk [*8])
      else $error("shift clock high phase too short");
   AST_SCLK_LOW: assert property ($fell(sclk) && !cs_n |=> !sclk [*8])
      else $error("shift clock low phase too short");
   AST_HOST_HOLD: assert property (sd_host_oe && sclk && $past(sclk) |-> $stable(ctrl_serial_io))
      else $error("host data moved while shift clock high");
   AST_DEV_OE_START: assert property ($rose(sd_dev_oe) |-> st_reg.rises == 5'h08 && $past(rw, 3))
      else $error("device drove line outside read data phase");
   AST_DEV_SELECT: assert property (sd_dev_oe |-> !$past(cs_n, 4))
      else $error("device drove line while deselected");
   AST_DEV_STABLE: assert property ($rose(sclk) && sd_dev_oe |-> $stable(sd_dev_o))
      else $error("device data moved at host sampling edge");
   AST_HOST_RELEASE: assert property (rw && st_reg.rises == 5'h08 && $fell(sclk) |-> ##[0:1] !sd_host_oe)
      else $error("host kept driving after read address");
   AST_DESELECT_DROP: assert property ($rose(cs_n) |-> ##[0:4] !sd_dev_oe)
      else $error("device still driving after deselect");
endmodule

// >>> serial_config_port_tb_top.sv
`timescale 1ns/1ns
module serial_config_port_tb_top;
   import scp_pkg::*;
   logic core_clk = 0, rst = 1, host_rst = 0, start = 0, rd = 0, busy, done, master_rst_n = 1;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, test_monitor;
   logic [31:0] rx_status, xs_st = 32'hF0FAB677;
   logic [REG_NUM_DEF*WORD_W-1:0] cfg_regs;
   logic cfg_wr_pulse, txrx_enable, standby, div2, div4, pend = 0;
   logic [5:0] cfg_wr_idx, pidx;
   logic [7:0] pval, mem [64];
   logic [8:0] op_q [$];
   logic [13:0] wr_q [$];
   int bad_count = 0, cmp_count = 0;
   logic [5:0] wr_list [6] = '{6'h01, 6'h07, 6'h17, 6'h1C, 6'h1E, 6'h1F};
   logic [5:0] ro_list [7] = '{6'h00, 6'h18, 6'h19, 6'h1A, 6'h1B, 6'h1D, 6'h28};

   always #2 core_clk = ~core_clk;

   scp_if bus ();
   scp_host #(.HALF_CYC(SCLK_HALF_CYC)) scp_host_inst (.core_clk(core_clk), .rst(rst || host_rst), .bus(bus),
      .start(start), .rd(rd), .addr(addr), .wdata(wdata), .busy(busy), .done(done), .rdata(rdata));
   scp_dev scp_dev_inst (.core_clk(core_clk), .rst(rst), .bus(bus), .master_rst_n(master_rst_n),
      .rx_status(rx_status), .test_monitor(test_monitor), .cfg_regs(cfg_regs), .cfg_wr_pulse(cfg_wr_pulse),
      .cfg_wr_idx(cfg_wr_idx), .txrx_enable(txrx_enable), .standby(standby), .xcvr_clk_div2(div2),
      .xcvr_clk_div4(div4));
   scp_properties scp_properties_inst (.core_clk(core_clk), .rst(rst || host_rst), .sclk(bus.sclk),
      .cs_n(bus.cs_n), .rw(bus.rw), .sd_host_oe(bus.sd_host_oe), .sd_dev_oe(bus.sd_dev_oe),
      .sd_dev_o(bus.sd_dev_o), .ctrl_serial_io(bus.ctrl_serial_io));

   function automatic logic [31:0] xs();
      xs_st = xs_st ^ (xs_st << 13);
      xs_st = xs_st ^ (xs_st >> 17);
      xs_st = xs_st ^ (xs_st << 5);
      return xs_st;
   endfunction

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic cmp_bit(input logic got, input logic exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t %s got %b expected %b", $time, what, got, exp);
      end
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // one host frame; abort_at > 0 resets the host that many cycles in
   task automatic run_op(input logic r, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e,
                         input int abort_at);
      int n;
      if (abort_at == 0) begin
         op_q.push_back({r, e});
      end
      @(posedge core_clk);
      #1 start = 1;
      rd = r;
      addr = a;
      wdata = d;
      @(posedge core_clk);
      #1 start = 0;
      cmp_bit(busy, 1'b1, "host busy");
      n = 0;
      while (done !== 1'b1 && n < 2000 && (abort_at == 0 || n < abort_at)) begin
         @(posedge core_clk);
         n++;
      end
      if (abort_at > 0) begin
         #1 host_rst = 1;
         @(posedge core_clk);
         #1 host_rst = 0;
         repeat (4) @(posedge core_clk);
      end else if (n >= 2000) begin
         bad_count++;
         $display("[ERR] %0t frame never completed", $time);
         wrap_up();
      end
   endtask

   // read results come back with done, oldest note first
   always @(posedge core_clk) begin
      if (done === 1'b1) begin
         if (op_q.size() == 0) begin
            cmp_bit(1'b1, 1'b0, "unexpected done");
         end else begin
            if (op_q[0][8]) begin
               cmp8(rdata, op_q[0][7:0], "read data");
            end
            void'(op_q.pop_front());
         end
      end
   end

   // write results: pulse and index now, register byte one cycle later
   always @(posedge core_clk) begin
      if (pend) begin
         cmp8(cfg_regs[int'(pidx)*8 +: 8], pval, "written byte");
      end
      pend = 0;
      if (cfg_wr_pulse === 1'b1) begin
         if (wr_q.size() == 0) begin
            cmp_bit(1'b1, 1'b0, "unexpected register write");
         end else begin
            {pidx, pval} = wr_q.pop_front();
            cmp8({2'b00, cfg_wr_idx}, {2'b00, pidx}, "write index");
            pend = 1;
         end
      end
   end

   initial begin
      logic [7:0] d, e;
      logic [1:0] lo;
      logic v2, v4;
      rx_status = xs();
      test_monitor = 8'(xs());
      repeat (3) @(posedge core_clk);
      #1 rst = 0;
      // writes then reads with other ignored low address bits, back to back
      foreach (wr_list[i]) begin
         d = 8'(xs());
         lo = 2'(xs());
         mem[wr_list[i]] = d;
         wr_q.push_back({wr_list[i], d});
         run_op(1'b0, {wr_list[i], lo}, d, 8'h00, 0);
         run_op(1'b1, {wr_list[i], ~lo}, 8'h00, d, 0);
      end
      $display("test write_read done");
      // fixed and out of range places refuse writes and read their own content
      foreach (ro_list[i]) begin
         case (ro_list[i])
            6'h00: e = PART_CODE;
            6'h1D: e = test_monitor;
            6'h28: e = 8'h00;
            default: e = rx_status[31 - 8 * (int'(ro_list[i]) - 24) -: 8];
         endcase
         run_op(1'b0, {ro_list[i], 2'b00}, 8'(xs()), 8'h00, 0);
         run_op(1'b1, {ro_list[i], 2'b11}, 8'h00, e, 0);
      end
      $display("test read_only done");
      // frames cut short by deselect in the read data phase and before the last write bit
      run_op(1'b1, {wr_list[1], 2'b00}, 8'h00, 8'h00, 240);
      run_op(1'b0, {wr_list[1], 2'b00}, ~mem[wr_list[1]], 8'h00, 365);
      run_op(1'b1, {wr_list[1], 2'b01}, 8'h00, mem[wr_list[1]], 0);
      $display("test abort done");
      // master reset: standby, transceiver off, registers kept
      cmp_bit(txrx_enable, 1'b1, "transceiver enable");
      #1 master_rst_n = 0;
      repeat (5) @(posedge core_clk);
      #1 cmp_bit(standby, 1'b1, "standby");
      cmp_bit(txrx_enable, 1'b0, "transceiver enable");
      master_rst_n = 1;
      repeat (5) @(posedge core_clk);
      #1 cmp_bit(standby, 1'b0, "standby");
      run_op(1'b1, {wr_list[2], 2'b10}, 8'h00, mem[wr_list[2]], 0);
      $display("test master_reset done");
      // divided transceiver clocks and unused three-wire input
      #1;
      for (int k = 0; k < 8; k++) begin
         v2 = div2;
         v4 = div4;
         @(posedge core_clk);
         #1 cmp_bit(div2, ~v2, "clock divided by 2");
         @(posedge core_clk);
         #1 cmp_bit(div4, ~v4, "clock divided by 4");
      end
      cmp_bit(bus.three_wire_data_in, 1'b0, "three-wire input level");
      $display("test clocks done");
      repeat (4) @(posedge core_clk);
      cmp_bit(op_q.size() == 0 && wr_q.size() == 0, 1'b1, "pending results");
      wrap_up();
   end
endmodule
